/* core/sfr_clk_if.sv */
`timescale 1ns/1ps
interface sfr_clk_if;
   logic run;
   logic ce;
   logic sclk;
   logic rise;
   logic fall;
   modport gen (input run, input ce, output sclk, output rise, output fall);
   modport eng (output run, output ce, input sclk, input rise, input fall);
endinterface

/* core/sfr_host.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Width change frames hold only the instruction byte between chip select edges.
// - Address bits sampled on rising clock, data driven on falling clock.
// - Plain read: instruction, address, no dummies, data until chip select rises.
// - Quick read: single-line instruction and address, 8 default dummies, serial data.
// - Dual-output read: lane 0 for command, address, dummies; data on lanes 1,0.
// - Dual-I/O read: address on lanes 1,0, 4 default dummies, two-lane data.
// - Quad-output read: single-line address, 8 default dummies, four-lane data.
// - Quad enable must be set before a quad-I/O read is issued.
// - Quad-I/O read: four-lane address, 6 default dummies, four-lane data.
// - Host drives the two indicator clocks and avoids the toggling pattern.
module sfr_host #(
   parameter int HALF = sfr_pkg::SCLK_HALF
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             cs_n,
   output logic             sclk,
   input  wire logic [3:0]  io_in,
   output logic      [3:0]  io_out,
   output logic      [3:0]  io_oe_n
);
   sfr_clk_if ck ();
   sfr_sclk_gen #(.HALF(HALF)) u_gen (.pclk(pclk), .presetn(presetn), .ck(ck));

   function automatic logic [3:0] lane_out(input logic [31:0] t, input logic [2:0] l);
      case (l)
         3'h1:    lane_out = {3'h0, t[31]};
         3'h2:    lane_out = {2'h0, t[31:30]};
         default: lane_out = t[31:28];
      endcase
   endfunction

   function automatic logic [3:0] lane_oe_n(input logic [2:0] l);
      case (l)
         3'h1:    lane_oe_n = 4'hE;
         3'h2:    lane_oe_n = 4'hC;
         default: lane_oe_n = 4'h0;
      endcase
   endfunction

   function automatic logic [5:0] clocks(input logic [5:0] bits, input logic [2:0] l);
      case (l)
         3'h1:    clocks = bits;
         3'h2:    clocks = bits >> 1;
         default: clocks = bits >> 2;
      endcase
   endfunction

   // Single-lane data returns on lane 1, the flash's serial output.
   function automatic logic [7:0] rx_shift(input logic [7:0] r, input logic [3:0] s,
                                           input logic [2:0] l);
      case (l)
         3'h1:    rx_shift = {r[6:0], s[1]};
         3'h2:    rx_shift = {r[5:0], s[1:0]};
         default: rx_shift = {r[3:0], s};
      endcase
   endfunction

   function automatic logic [2:0] data_lanes(input sfr_pkg::sfr_op_t op);
      case (op)
         sfr_pkg::OP_DOUT, sfr_pkg::OP_DIO: data_lanes = 3'h2;
         sfr_pkg::OP_QOUT, sfr_pkg::OP_QIO: data_lanes = 3'h4;
         default:                           data_lanes = 3'h1;
      endcase
   endfunction

   // APB slave registers.
   logic [31:0] addr_r, next_addr_r, next_prdata;
   logic [15:0] len_r, next_len_r;
   logic [3:0]  cfg_r, next_cfg_r;
   logic        next_pready, next_pslverr;
   logic        acc, start_req, clr_refused, pop;

   // Engine state.
   sfr_pkg::sfr_state_t state, next_state;
   sfr_pkg::sfr_op_t    op, next_op, start_op;
   logic [31:0] tx, next_tx;
   logic [2:0]  lanes, next_lanes;
   logic [5:0]  cnt, next_cnt, limit, next_limit;
   logic [7:0]  rx, next_rx, hold, next_hold;
   logic [15:0] remain, next_remain;
   logic [1:0]  dc, next_dc;
   logic        valid, next_valid, refused, next_refused, wide, next_wide;
   logic        next_cs_n;
   logic [3:0]  next_io_out, next_io_oe_n;
   logic [3:0]  sync1, sync2;
   logic        legal, go_data;
   logic [5:0]  dum;

   assign acc         = psel && penable && pready;
   assign start_req   = acc && pwrite && paddr == sfr_pkg::OFF_CTRL;
   assign start_op    = sfr_pkg::sfr_op_t'(pwdata[sfr_pkg::CTRL_OP_LSB +: 3]);
   assign clr_refused = acc && pwrite && paddr == sfr_pkg::OFF_STATUS
                        && pwdata[sfr_pkg::STAT_REF_BIT];
   assign pop         = acc && !pwrite && paddr == sfr_pkg::OFF_DATA;
   assign sclk        = ck.sclk;
   assign ck.ce       = ce;
   assign ck.run      = state != sfr_pkg::ST_IDLE
                        && !(state == sfr_pkg::ST_DATA && cnt == 6'h00 && valid);

   always_comb begin
      next_addr_r  = addr_r;
      next_len_r   = len_r;
      next_cfg_r   = cfg_r;
      next_prdata  = prdata;
      next_pready  = psel && !penable;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         case (paddr)
            sfr_pkg::OFF_CTRL:   next_prdata = {28'h000_0000, 1'b0, op};
            sfr_pkg::OFF_STATUS: next_prdata = {28'h000_0000, wide, refused, valid,
                                                state != sfr_pkg::ST_IDLE};
            sfr_pkg::OFF_ADDR:   next_prdata = addr_r;
            sfr_pkg::OFF_LEN:    next_prdata = {16'h0000, len_r};
            sfr_pkg::OFF_CFG:    next_prdata = {28'h000_0000, cfg_r};
            sfr_pkg::OFF_DATA:   next_prdata = {24'h00_0000, hold};
            default: begin
               next_prdata  = 32'h0000_0000;
               next_pslverr = 1'b1;
            end
         endcase
      end
      if (acc && pwrite) begin
         case (paddr)
            sfr_pkg::OFF_ADDR: next_addr_r = pwdata;
            sfr_pkg::OFF_LEN:  next_len_r  = pwdata[15:0];
            sfr_pkg::OFF_CFG:  next_cfg_r  = pwdata[3:0];
            default:           next_cfg_r  = cfg_r;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r  <= sfr_pkg::ADDR_RST;
         len_r   <= sfr_pkg::LEN_RST;
         cfg_r   <= sfr_pkg::CFG_RST;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         addr_r  <= next_addr_r;
         len_r   <= next_len_r;
         cfg_r   <= next_cfg_r;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Pins from the flash are foreign to pclk.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else if (ce) begin
         sync1 <= io_in;
         sync2 <= sync1;
      end
   end

   always_comb begin
      next_state   = state;
      next_op      = op;
      next_tx      = tx;
      next_lanes   = lanes;
      next_cnt     = cnt;
      next_limit   = limit;
      next_rx      = rx;
      next_hold    = hold;
      next_remain  = remain;
      next_dc      = dc;
      next_valid   = valid;
      next_refused = refused;
      next_wide    = wide;
      next_cs_n    = cs_n;
      next_io_out  = io_out;
      next_io_oe_n = io_oe_n;
      go_data      = 1'b0;
      dum          = sfr_pkg::dummy_clocks(dc, op);
      // Quick, dual and quad reads are held back while software flags a write cycle.
      legal = !(start_op != sfr_pkg::OP_ENTER && start_op != sfr_pkg::OP_EXIT
                && start_op != sfr_pkg::OP_READ && cfg_r[sfr_pkg::CFG_WIP_BIT])
              && !(start_op == sfr_pkg::OP_QIO && !cfg_r[sfr_pkg::CFG_QE_BIT])
              && !(start_op != sfr_pkg::OP_ENTER && start_op != sfr_pkg::OP_EXIT
                   && len_r == 16'h0000);
      if (clr_refused) begin
         next_refused = 1'b0;
      end
      if (pop) begin
         next_valid = 1'b0;
      end
      if (ck.rise && state != sfr_pkg::ST_IDLE) begin
         next_cnt = cnt + 6'h01;
      end
      if (start_req && (state != sfr_pkg::ST_IDLE || !legal)) begin
         next_refused = 1'b1;
      end
      case (state)
         sfr_pkg::ST_IDLE: begin
            if (start_req && legal) begin
               next_state = sfr_pkg::ST_CMD;
               next_op    = start_op;
               next_dc    = cfg_r[sfr_pkg::CFG_DC_LSB +: 2];
               next_lanes = (start_op == sfr_pkg::OP_QIO && pwdata[sfr_pkg::CTRL_QCM_BIT])
                            ? 3'h4 : 3'h1;
               next_tx      = {sfr_pkg::opcode(start_op), 24'h00_0000};
               next_io_out  = lane_out(next_tx, next_lanes);
               next_io_oe_n = lane_oe_n(next_lanes);
               next_cs_n    = 1'b0;
               next_cnt     = 6'h00;
               next_limit   = clocks(6'h08, next_lanes);
               next_remain  = len_r;
            end
         end
         sfr_pkg::ST_CMD, sfr_pkg::ST_ADDR: begin
            if (ck.fall && cnt != limit) begin
               next_tx     = tx << lanes;
               next_io_out = lane_out(next_tx, lanes);
            end else if (ck.fall && state == sfr_pkg::ST_CMD
                         && (op == sfr_pkg::OP_ENTER || op == sfr_pkg::OP_EXIT)) begin
               next_state   = sfr_pkg::ST_IDLE;
               next_cs_n    = 1'b1;
               next_io_oe_n = 4'hF;
               next_wide    = op == sfr_pkg::OP_ENTER;
            end else if (ck.fall && state == sfr_pkg::ST_CMD) begin
               next_state = sfr_pkg::ST_ADDR;
               next_lanes = (op == sfr_pkg::OP_DIO) ? 3'h2 :
                            (op == sfr_pkg::OP_QIO) ? 3'h4 : 3'h1;
               next_tx    = wide ? addr_r : {addr_r[23:0], 8'h00};
               next_limit = clocks(wide ? 6'h20 : 6'h18, next_lanes);
               next_cnt   = 6'h00;
               next_io_out  = lane_out(next_tx, next_lanes);
               next_io_oe_n = lane_oe_n(next_lanes);
            end else if (ck.fall) begin
               next_cnt = 6'h00;
               if (dum == 6'h00) begin
                  go_data = 1'b1;
               end else begin
                  next_state  = sfr_pkg::ST_DUMMY;
                  next_limit  = dum;
                  next_io_out = 4'h0;
                  next_io_oe_n = (op == sfr_pkg::OP_QIO) ? 4'h0 :
                                 (op == sfr_pkg::OP_DIO) ? 4'hF : 4'hE;
               end
            end
         end
         sfr_pkg::ST_DUMMY: begin
            if (ck.fall && cnt == limit) begin
               go_data = 1'b1;
            end else if (ck.fall && cnt == 6'h02) begin
               next_io_oe_n = 4'hF;
            end
         end
         sfr_pkg::ST_DATA: begin
            if (ck.rise) begin
               next_rx = rx_shift(rx, sync2, lanes);
               if (cnt + 6'h01 == limit) begin
                  next_hold   = next_rx;
                  next_valid  = 1'b1;
                  next_cnt    = 6'h00;
                  next_remain = remain - 16'h0001;
                  if (remain == 16'h0001) begin
                     next_state = sfr_pkg::ST_END;
                  end
               end
            end
         end
         sfr_pkg::ST_END: begin
            if (ck.fall) begin
               next_state   = sfr_pkg::ST_IDLE;
               next_cs_n    = 1'b1;
               next_io_oe_n = 4'hF;
            end
         end
         default: begin
            next_state = sfr_pkg::ST_IDLE;
            next_cs_n  = 1'b1;
         end
      endcase
      if (go_data) begin
         next_state   = sfr_pkg::ST_DATA;
         next_lanes   = data_lanes(op);
         next_limit   = clocks(6'h08, next_lanes);
         next_cnt     = 6'h00;
         next_io_oe_n = 4'hF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= sfr_pkg::ST_IDLE;
         op      <= sfr_pkg::OP_READ;
         tx      <= 32'h0000_0000;
         lanes   <= 3'h1;
         cnt     <= 6'h00;
         limit   <= 6'h00;
         rx      <= 8'h00;
         hold    <= 8'h00;
         remain  <= 16'h0000;
         dc      <= 2'h0;
         valid   <= 1'b0;
         refused <= 1'b0;
         wide    <= 1'b0;
         cs_n    <= 1'b1;
         io_out  <= 4'h0;
         io_oe_n <= 4'hF;
      end else if (ce) begin
         state   <= next_state;
         op      <= next_op;
         tx      <= next_tx;
         lanes   <= next_lanes;
         cnt     <= next_cnt;
         limit   <= next_limit;
         rx      <= next_rx;
         hold    <= next_hold;
         remain  <= next_remain;
         dc      <= next_dc;
         valid   <= next_valid;
         refused <= next_refused;
         wide    <= next_wide;
         cs_n    <= next_cs_n;
         io_out  <= next_io_out;
         io_oe_n <= next_io_oe_n;
      end
   end

   property p_width_frame;
      @(posedge pclk) disable iff (!presetn)
         ce && state == sfr_pkg::ST_CMD && ck.fall && cnt == limit
         && (op == sfr_pkg::OP_ENTER || op == sfr_pkg::OP_EXIT)
         |=> cs_n && io_oe_n == 4'hF && wide == (op == sfr_pkg::OP_ENTER);
   endproperty
   a_width_frame: assert property (p_width_frame) else $error("width frame wrong");

   property p_drive_on_fall;
      @(posedge pclk) disable iff (!presetn)
         !$stable(io_out) && !$past(cs_n) && state != sfr_pkg::ST_CMD |-> $past(ck.fall);
   endproperty
   a_drive_on_fall: assert property (p_drive_on_fall) else $error("io moved off fall");

   property p_plain_no_dummy;
      @(posedge pclk) disable iff (!presetn)
         op == sfr_pkg::OP_READ |-> state != sfr_pkg::ST_DUMMY;
   endproperty
   a_plain_no_dummy: assert property (p_plain_no_dummy) else $error("plain read dummy");

   property p_data_released;
      @(posedge pclk) disable iff (!presetn)
         $rose(state == sfr_pkg::ST_DATA) |-> io_oe_n == 4'hF && cnt == 6'h00;
   endproperty
   a_data_released: assert property (p_data_released) else $error("lanes held");

   property p_dio_addr;
      @(posedge pclk) disable iff (!presetn)
         state == sfr_pkg::ST_ADDR && op == sfr_pkg::OP_DIO |-> io_oe_n == 4'hC;
   endproperty
   a_dio_addr: assert property (p_dio_addr) else $error("dual address lanes");

   property p_qio_addr;
      @(posedge pclk) disable iff (!presetn)
         state == sfr_pkg::ST_ADDR && op == sfr_pkg::OP_QIO |-> io_oe_n == 4'h0;
   endproperty
   a_qio_addr: assert property (p_qio_addr) else $error("quad address lanes");

   property p_qe_first;
      @(posedge pclk) disable iff (!presetn)
         $rose(state == sfr_pkg::ST_CMD) && op == sfr_pkg::OP_QIO
         |-> $past(cfg_r[sfr_pkg::CFG_QE_BIT]);
   endproperty
   a_qe_first: assert property (p_qe_first) else $error("quad read without enable");

   property p_indicator;
      @(posedge pclk) disable iff (!presetn)
         state == sfr_pkg::ST_DUMMY && op == sfr_pkg::OP_QIO && cnt < 6'h02
         |-> io_oe_n == 4'h0 && io_out == 4'h0;
   endproperty
   a_indicator: assert property (p_indicator) else $error("indicator not driven");

   property p_busy_refused;
      @(posedge pclk) disable iff (!presetn)
         ce && state == sfr_pkg::ST_IDLE && start_req && cfg_r[sfr_pkg::CFG_WIP_BIT]
         && start_op == sfr_pkg::OP_FAST |=> refused && state == sfr_pkg::ST_IDLE;
   endproperty
   a_busy_refused: assert property (p_busy_refused) else $error("busy read issued");

   property p_end_frame;
      @(posedge pclk) disable iff (!presetn)
         ce && state == sfr_pkg::ST_END && ck.fall
         |=> cs_n && io_oe_n == 4'hF && state == sfr_pkg::ST_IDLE;
   endproperty
   a_end_frame: assert property (p_end_frame) else $error("frame not closed");
endmodule

/* core/sfr_pkg.sv */
package sfr_pkg;
   // Register offsets on the APB side.
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_ADDR   = 8'h08;
   localparam logic [7:0] OFF_LEN    = 8'h0C;
   localparam logic [7:0] OFF_CFG    = 8'h10;
   localparam logic [7:0] OFF_DATA   = 8'h14;
   // Field positions.
   localparam int CTRL_OP_LSB   = 0;
   localparam int CTRL_QCM_BIT  = 3;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_VAL_BIT  = 1;
   localparam int STAT_REF_BIT  = 2;
   localparam int STAT_WIDE_BIT = 3;
   localparam int CFG_DC_LSB    = 0;
   localparam int CFG_QE_BIT    = 2;
   localparam int CFG_WIP_BIT   = 3;
   // Reset values.
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [15:0] LEN_RST  = 16'h0001;
   localparam logic [3:0]  CFG_RST  = 4'h0;
   // Instruction codes.
   localparam logic [7:0] OPC_ENTER = 8'hB7;
   localparam logic [7:0] OPC_EXIT  = 8'hE9;
   localparam logic [7:0] OPC_READ  = 8'h03;
   localparam logic [7:0] OPC_FAST  = 8'h0B;
   localparam logic [7:0] OPC_DOUT  = 8'h3B;
   localparam logic [7:0] OPC_DIO   = 8'hBB;
   localparam logic [7:0] OPC_QOUT  = 8'h6B;
   localparam logic [7:0] OPC_QIO   = 8'hEB;
   // Dummy clock figures.
   localparam logic [5:0] DUM_4  = 6'h04;
   localparam logic [5:0] DUM_6  = 6'h06;
   localparam logic [5:0] DUM_8  = 6'h08;
   localparam logic [5:0] DUM_10 = 6'h0A;
   // Serial clock timing.
   localparam int PCLK_PERIOD_NS = 40;
   localparam int SCLK_PERIOD_NS = 320;
   localparam int SCLK_HALF      = SCLK_PERIOD_NS / (2 * PCLK_PERIOD_NS);

   typedef enum logic [2:0] {
      OP_ENTER = 3'h0, OP_EXIT = 3'h1, OP_READ = 3'h2, OP_FAST = 3'h3,
      OP_DOUT  = 3'h4, OP_DIO  = 3'h5, OP_QOUT = 3'h6, OP_QIO  = 3'h7
   } sfr_op_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01, ST_CMD = 6'h02, ST_ADDR = 6'h04,
      ST_DUMMY = 6'h08, ST_DATA = 6'h10, ST_END = 6'h20
   } sfr_state_t;

   function automatic logic [7:0] opcode(input sfr_op_t op);
      case (op)
         OP_ENTER: opcode = OPC_ENTER;
         OP_EXIT:  opcode = OPC_EXIT;
         OP_READ:  opcode = OPC_READ;
         OP_FAST:  opcode = OPC_FAST;
         OP_DOUT:  opcode = OPC_DOUT;
         OP_DIO:   opcode = OPC_DIO;
         OP_QOUT:  opcode = OPC_QOUT;
         default:  opcode = OPC_QIO;
      endcase
   endfunction

   function automatic logic [5:0] dummy_clocks(input logic [1:0] dc, input sfr_op_t op);
      dummy_clocks = DUM_8;
      case (dc)
         2'h0: dummy_clocks = (op == OP_DIO) ? DUM_4 : (op == OP_QIO) ? DUM_6 : DUM_8;
         2'h1: dummy_clocks = (op == OP_QIO) ? DUM_4 : DUM_6;
         2'h2: dummy_clocks = DUM_8;
         default: dummy_clocks = DUM_10;
      endcase
      if (op == OP_READ) begin
         dummy_clocks = 6'h00;
      end
   endfunction
endpackage

/* core/sfr_sclk_gen.sv */
`timescale 1ns/1ps
module sfr_sclk_gen #(
   parameter int HALF = sfr_pkg::SCLK_HALF
) (
   input wire logic pclk,
   input wire logic presetn,
   sfr_clk_if.gen   ck
);
   // Input sampling takes up to three pclk cycles, so a half period must exceed it.
   if (HALF < 4 || HALF > 255) begin : g_chk
      $error("HALF must lie between 4 and 255");
   end

   logic [7:0] cnt, next_cnt;
   logic       next_sclk, next_rise, next_fall;

   always_comb begin
      next_cnt  = cnt + 8'h01;
      next_sclk = ck.sclk;
      next_rise = 1'b0;
      next_fall = 1'b0;
      if (!ck.sclk && !ck.run) begin
         next_cnt = 8'h00;
      end else if (cnt == 8'(HALF - 1)) begin
         next_cnt  = 8'h00;
         next_sclk = !ck.sclk;
         next_rise = !ck.sclk;
         next_fall = ck.sclk;
      end
   end

   // A stop request only takes effect with the clock low, so a started pulse always ends.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt     <= 8'h00;
         ck.sclk <= 1'b0;
         ck.rise <= 1'b0;
         ck.fall <= 1'b0;
      end else if (ck.ce) begin
         cnt     <= next_cnt;
         ck.sclk <= next_sclk;
         ck.rise <= next_rise;
         ck.fall <= next_fall;
      end
   end

   property p_half_width;
      @(posedge pclk) disable iff (!presetn)
         ck.ce && ck.rise |-> !ck.fall;
   endproperty
   a_half_width: assert property (p_half_width) else $error("rise and fall together");
endmodule

/* verif/serial_flash_read_address_mode_test.sv */
`timescale 1ns/1ps
module serial_flash_read_address_mode_test;
   localparam logic [31:0] TOP = 32'h01FF_FFFF;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        chk = 1'b0, qcm = 1'b0, wip = 1'b0, pready, pslverr, cs_n, sclk;
   logic [1:0]  dc = 2'h0;
   logic [3:0]  io_out, io_oe_n, fo, foe, lanes;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r;
   logic [32:0] q[$];
   integer      seed = 32'h4b13;
   int          fail_count = 0, n_compared = 0;
   // Lanes nobody drives are pulled up, so a released lane never shows stale data.
   assign lanes = (~io_oe_n & io_out) | (io_oe_n & foe & fo) | (io_oe_n & ~foe);
   sfr_host #(.HALF(4)) dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .io_in(lanes),
      .io_out(io_out), .io_oe_n(io_oe_n));
   sfr_flash_model #(.MTOP(TOP)) flash_u (.cs_n(cs_n), .sclk(sclk), .qcm(qcm), .wip(wip),
      .dc(dc), .io(lanes), .fo(fo), .foe(foe));
   initial forever #20 pclk = ~pclk;
   function automatic logic [32:0] fd(input logic [31:0] a);
      fd = {25'h0, a[7:0] + a[24:17] + 8'h11};
   endfunction
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic c,
                      input logic [32:0] e);
      @(posedge pclk);
      if (c) q.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      chk <= c;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      chk <= 1'b0;
   endtask
   always @(posedge pclk)
      if (chk && penable && pready === 1'b1) check({pslverr, prdata}, q.pop_front());
   task automatic run(input logic [3:0] ctl, input logic [31:0] a, input logic [31:0] ea,
                      input logic [15:0] len, input int nb);
      apb(1'b1, sfr_pkg::OFF_ADDR, a, 1'b0, 33'h0);
      apb(1'b1, sfr_pkg::OFF_LEN, {16'h0, len}, 1'b0, 33'h0);
      apb(1'b1, sfr_pkg::OFF_CFG, {28'h0, wip, 1'b1, dc}, 1'b0, 33'h0);
      apb(1'b1, sfr_pkg::OFF_CTRL, {28'h0, ctl}, 1'b0, 33'h0);
      repeat (nb) begin
         r = 32'h0;
         while (r[1] !== 1'b1) apb(1'b0, sfr_pkg::OFF_STATUS, 32'h0, 1'b0, 33'h0);
         apb(1'b0, sfr_pkg::OFF_DATA, 32'h0, 1'b1, fd(ea));
         ea = (ea == TOP) ? 32'h0 : ea + 32'h1;
      end
      r = 32'h1;
      while (r[0] !== 1'b0) apb(1'b0, sfr_pkg::OFF_STATUS, 32'h0, 1'b0, 33'h0);
      $display("test with control %h done", ctl);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, sfr_pkg::OFF_STATUS, 32'h0, 1'b1, 33'h0);
      apb(1'b0, 8'h18, 32'h0, 1'b1, {1'b1, 32'h0});
      run(4'h2, 32'h00FF_FFFE, 32'h00FF_FFFE, 16'h3, 3);
      run(4'h0, 32'h0, 32'h0, 16'h0, 0);
      apb(1'b0, sfr_pkg::OFF_STATUS, 32'h0, 1'b1, 33'h8);
      for (int k = 3; k < 9; k++) begin
         dc <= 2'($random(seed));
         qcm <= (k == 8);
         run({k == 8, 3'(k == 8 ? 7 : k)}, TOP, TOP, 16'h2, 2);
      end
      wip <= 1'b1;
      qcm <= 1'b0;
      run(4'h3, TOP, TOP, 16'h1, 0);
      apb(1'b0, sfr_pkg::OFF_STATUS, 32'h0, 1'b1, 33'hC);
      apb(1'b1, sfr_pkg::OFF_STATUS, 32'h4, 1'b0, 33'h0);
      run(4'h2, 32'h0000_0010, 32'h0000_0010, 16'h1, 1);
      wip <= 1'b0;
      run(4'h1, 32'h0, 32'h0, 16'h0, 0);
      apb(1'b0, sfr_pkg::OFF_STATUS, 32'h0, 1'b1, 33'h0);
      apb(1'b1, sfr_pkg::OFF_CFG, 32'h0, 1'b0, 33'h0);
      apb(1'b1, sfr_pkg::OFF_CTRL, 32'h7, 1'b0, 33'h0);
      apb(1'b0, sfr_pkg::OFF_STATUS, 32'h0, 1'b1, 33'h4);
      apb(1'b1, sfr_pkg::OFF_STATUS, 32'h4, 1'b0, 33'h0);
      $display("test with quad enable clear done");
      run(4'h2, TOP, 32'h00FF_FFFF, 16'h1, 1);
      results();
   end
   initial begin
      repeat (60000) @(posedge pclk);
      fail_count++;
      results();
   end
endmodule

/* verif/sfr_flash_model.sv */
`timescale 1ns/1ps
// A byte reads as a[7:0] + a[24:17] + 8'h11, so a truncated address shows up in the data.
module sfr_flash_model #(
   parameter logic [31:0] MTOP = 32'h01FF_FFFF
) (
   input  wire logic       cs_n,
   input  wire logic       sclk,
   input  wire logic       qcm,
   input  wire logic       wip,
   input  wire logic [1:0] dc,
   input  wire logic [3:0] io,
   output logic      [3:0] fo,
   output logic      [3:0] foe
);
   logic [7:0]  op, sh;
   logic [31:0] a;
   logic        wide = 1'b0;
   logic        rej = 1'b1;
   int          n, cc, al, dl, ae, de, dm, bc;
   initial foe = 4'h0;
   initial fo = 4'h0;
   always @(negedge cs_n) begin
      n = 0;
      bc = 0;
      ae = 0;
      de = 1000;
      a = 32'h0000_0000;
      cc = qcm ? 2 : 8;
   end
   always @(posedge cs_n) begin
      foe <= 4'h0;
      if (n == 8 && op == sfr_pkg::OPC_ENTER) wide = 1'b1;
      if (n == 8 && op == sfr_pkg::OPC_EXIT) wide = 1'b0;
   end
   always @(posedge sclk) if (!cs_n) begin
      n = n + 1;
      if (n <= cc) op = qcm ? {op[3:0], io} : {op[6:0], io[0]};
      if (n == cc) begin
         al = (op == sfr_pkg::OPC_DIO) ? 2 : (op == sfr_pkg::OPC_QIO) ? 4 : 1;
         dl = (op == sfr_pkg::OPC_DOUT || op == sfr_pkg::OPC_DIO) ? 2 : 1;
         if (op == sfr_pkg::OPC_QOUT || op == sfr_pkg::OPC_QIO) dl = 4;
         ae = cc + (wide ? 32 : 24) / al;
         dm = dc[1] ? (dc[0] ? 10 : 8) : (dc[0] ? 6 : 8);
         if (op == sfr_pkg::OPC_DIO && !dc[1]) dm = dc[0] ? 6 : 4;
         if (op == sfr_pkg::OPC_QIO && !dc[1]) dm = dc[0] ? 4 : 6;
         de = ae + ((op == sfr_pkg::OPC_READ) ? 0 : dm);
         rej = wip && op != sfr_pkg::OPC_READ;
      end else if (n > cc && n <= ae) a = (a << al) | (io & ~(4'hF << al));
   end
   // Data leaves on the falling edge so the host sees it settled at the next rise.
   always @(negedge sclk) if (!cs_n && !rej && n >= de && n > cc) begin
      if (bc == 0) sh = a[7:0] + a[24:17] + 8'h11;
      fo <= (dl == 1) ? {2'b00, sh[7], 1'b0} : (dl == 2) ? {2'b00, sh[7:6]} : sh[7:4];
      foe <= (dl == 1) ? 4'h2 : (dl == 2) ? 4'h3 : 4'hF;
      sh = sh << dl;
      bc = bc + dl;
      if (bc == 8) begin
         bc = 0;
         a = (a == MTOP) ? 32'h0000_0000 : a + 32'h1;
      end
   end
endmodule
